/* File: core/temp_window.sv */
// Banked register window: sideband temperatures or serial master data buffer.
// Assumes APB master on pclk; temperature feed and serial engine on pclk too.
//
// What this block does
// - Bank 0 index E0 gives sensor reading, or max of cpu/hub readings.
// - Bank select 0 shows temperatures, 1 shows buffer bytes at E0-E7.
// - Buffer byte 0 carries single, first-word and tenth-block data bytes.
// - Buffer byte 1 carries second word byte and eleventh block byte.
// - Bank 0 index E1 is read-only platform hub temperature.
// - Bank 0 index E2 is cpu fraction byte; bit 0 flags error.
// - Buffer byte 2 is twelfth block-read and third block-write byte.
// - Bank 0 index E3 is read-only cpu whole-degree byte.
// - Buffer byte 3 is thirteenth block-read and fourth block-write byte.
// - Bank 0 index E4 is read-only memory hub temperature.
// - Buffer byte 4 is fourteenth block-read and fifth block-write byte.
// - Bank 0 index E5 is read-only module 0 temperature.
// - Buffer byte 5 is fifteenth block-read and sixth block-write byte.
// - Bank 0 index E6 is read-only module 1 temperature.
// - Buffer byte 6 is sixteenth block-read and seventh block-write byte.
// - Bank 0 index E7 is read-only module 2 temperature, reset zero.
// - Buffer byte 7 is seventeenth block-read and eighth block-write byte.
// - Buffer bytes at E0-E7 are host read/write, reset zero.
// - Bank select is bit 7 of the block count register.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
module temp_window
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Temperature feed
  input wire logic temp_update,
  input wire logic [7:0] cpu_sensor_temp,
  input wire logic [7:0] platform_hub_temp,
  input wire logic [7:0] cpu_fraction_temp,
  input wire logic [7:0] cpu_whole_temp,
  input wire logic [7:0] memory_hub_temp,
  input wire logic [7:0] module0_temp,
  input wire logic [7:0] module1_temp,
  input wire logic [7:0] module2_temp,
  // Serial engine side of the buffer
  input wire logic engine_we,
  input wire logic [2:0] engine_index,
  input wire logic [7:0] engine_wdata,
  output logic [63:0] buffer_bytes,
  output logic [5:0] block_count,
  output logic bank_select,
  output logic sideband_mode
);

  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic bank_select_r;
  logic [5:0] block_count_r;
  logic sideband_mode_r;
  logic [7:0] buf_r [8];
  logic [7:0] cpu_max_r;
  logic [7:0] platform_hub_r;
  logic [7:0] cpu_fraction_r;
  logic [7:0] cpu_whole_r;
  logic [7:0] memory_hub_r;
  logic [7:0] module0_r;
  logic [7:0] module1_r;
  logic [7:0] module2_r;
  logic [7:0] idx;
  logic addr_ok;
  logic in_window;
  logic mapped;
  logic access;
  logic write_fire;
  logic [7:0] hub_max;
  logic [7:0] cpu_max_nxt;
  logic [7:0] temp_byte;
  logic [31:0] rd_nxt;

  assign idx = paddr[temp_window_pkg::IDX_MSB:temp_window_pkg::IDX_LSB];
  assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign in_window = addr_ok && (idx >= temp_window_pkg::IDX_BYTE0)
    && (idx <= temp_window_pkg::IDX_BYTE7);
  assign mapped = in_window
    || (addr_ok && (idx == temp_window_pkg::IDX_BLOCK_COUNT))
    || (addr_ok && (idx == temp_window_pkg::IDX_SIDEBAND_CTRL));
  // One wait state: access cycle, then pready
  assign access = psel && penable && !pready_r;
  assign write_fire = psel && penable && pready_r && pwrite;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign bank_select = bank_select_r;
  assign block_count = block_count_r;
  assign sideband_mode = sideband_mode_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
    end
    else
    begin
      pready_r <= access;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else if (access)
    begin
      pslverr_r <= !mapped;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
    else
    begin
      pslverr_r <= 1'b0;
    end
  end

  // Bank select shares the block count register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bank_select_r <= temp_window_pkg::BANK_RESET;
      block_count_r <= temp_window_pkg::COUNT_RESET;
    end
    else if (write_fire && addr_ok && (idx == temp_window_pkg::IDX_BLOCK_COUNT))
    begin
      bank_select_r <= pwdata[temp_window_pkg::BANK_SELECT_BIT];
      block_count_r <= pwdata[temp_window_pkg::BLOCK_COUNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sideband_mode_r <= temp_window_pkg::MODE_RESET;
    end
    else if (write_fire && addr_ok && (idx == temp_window_pkg::IDX_SIDEBAND_CTRL))
    begin
      sideband_mode_r <= pwdata[temp_window_pkg::SIDEBAND_MODE_BIT];
    end
  end

  // Buffer bytes; engine write wins over a host write in the same cycle
  genvar g;
  generate
    for (g = 0; g < temp_window_pkg::NUM_BYTES; g++)
    begin : g_buf
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          buf_r[g] <= temp_window_pkg::BYTE_RESET;
        end
        else if (engine_we && (engine_index == 3'(g)))
        begin
          buf_r[g] <= engine_wdata;
        end
        else if (write_fire && in_window
          && (bank_select_r == temp_window_pkg::BANK_BUFFER)
          && (idx == temp_window_pkg::IDX_BYTE0 + 8'(g)))
        begin
          buf_r[g] <= pwdata[7:0];
        end
      end
      assign buffer_bytes[8*g+7:8*g] = buf_r[g];
    end
  endgenerate

  always_comb
  begin
    hub_max = (memory_hub_temp > platform_hub_temp) ? memory_hub_temp : platform_hub_temp;
    if (sideband_mode_r)
    begin
      cpu_max_nxt = (cpu_whole_temp > hub_max) ? cpu_whole_temp : hub_max;
    end
    else
    begin
      cpu_max_nxt = cpu_sensor_temp;
    end
  end

  // Feed update wins over a host write to index E0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_max_r <= temp_window_pkg::BYTE_RESET;
    end
    else if (temp_update)
    begin
      cpu_max_r <= cpu_max_nxt;
    end
    else if (write_fire && (bank_select_r == temp_window_pkg::BANK_TEMPERATURE)
      && addr_ok && (idx == temp_window_pkg::IDX_BYTE0))
    begin
      cpu_max_r <= pwdata[7:0];
    end
  end

  // Read-only readings: only the feed changes them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      platform_hub_r <= temp_window_pkg::BYTE_RESET;
      cpu_fraction_r <= temp_window_pkg::BYTE_RESET;
      cpu_whole_r <= temp_window_pkg::BYTE_RESET;
      memory_hub_r <= temp_window_pkg::BYTE_RESET;
      module0_r <= temp_window_pkg::BYTE_RESET;
      module1_r <= temp_window_pkg::BYTE_RESET;
      module2_r <= temp_window_pkg::BYTE_RESET;
    end
    else if (temp_update)
    begin
      platform_hub_r <= platform_hub_temp;
      cpu_fraction_r <= cpu_fraction_temp;
      cpu_whole_r <= cpu_whole_temp;
      memory_hub_r <= memory_hub_temp;
      module0_r <= module0_temp;
      module1_r <= module1_temp;
      module2_r <= module2_temp;
    end
  end

  always_comb
  begin
    unique case (idx)
      temp_window_pkg::IDX_BYTE0: temp_byte = cpu_max_r;
      temp_window_pkg::IDX_BYTE1: temp_byte = platform_hub_r;
      temp_window_pkg::IDX_BYTE2: temp_byte = cpu_fraction_r;
      temp_window_pkg::IDX_BYTE3: temp_byte = cpu_whole_r;
      temp_window_pkg::IDX_BYTE4: temp_byte = memory_hub_r;
      temp_window_pkg::IDX_BYTE5: temp_byte = module0_r;
      temp_window_pkg::IDX_BYTE6: temp_byte = module1_r;
      temp_window_pkg::IDX_BYTE7: temp_byte = module2_r;
      default: temp_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (in_window)
    begin
      if (bank_select_r == temp_window_pkg::BANK_BUFFER)
      begin
        rd_nxt = {24'h00_0000, buf_r[idx[2:0]]};
      end
      else
      begin
        rd_nxt = {24'h00_0000, temp_byte};
      end
    end
    else if (addr_ok && (idx == temp_window_pkg::IDX_BLOCK_COUNT))
    begin
      rd_nxt = {24'h00_0000, bank_select_r, 1'b0, block_count_r};
    end
    else if (addr_ok && (idx == temp_window_pkg::IDX_SIDEBAND_CTRL))
    begin
      rd_nxt = {31'h0000_0000, sideband_mode_r};
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_wait_state: assert property (access |=> pready_r ##1 !pready_r)
    else $error("pready not one cycle after access");
  chk_unmapped_err: assert property (access && !mapped |=> pslverr_r && pready_r)
    else $error("unmapped access not flagged");
  chk_bank_write: assert property (write_fire && addr_ok
    && (idx == temp_window_pkg::IDX_BLOCK_COUNT) |=> bank_select_r == $past(pwdata[7]))
    else $error("bank select not taken from bit 7");
  chk_max_mode: assert property (temp_update && sideband_mode_r |=> cpu_max_r >= cpu_whole_r
    && cpu_max_r >= memory_hub_r && cpu_max_r >= platform_hub_r)
    else $error("cpu max not highest reading");
  chk_fraction_load: assert property (temp_update |=> cpu_fraction_r == $past(cpu_fraction_temp))
    else $error("fraction byte not loaded");
  chk_ro_ignored: assert property (write_fire && !bank_select_r && in_window
    && (idx != temp_window_pkg::IDX_BYTE0) && !engine_we && !temp_update
    |=> $stable(buffer_bytes) && $stable(module2_r) && $stable(platform_hub_r))
    else $error("read-only write changed state");
  chk_buffer_write: assert property (write_fire && bank_select_r && in_window && !engine_we
    |=> buf_r[$past(idx[2:0])] == $past(pwdata[7:0]))
    else $error("buffer byte not written");
  chk_engine_byte: assert property (engine_we |=> buf_r[$past(engine_index)] == $past(engine_wdata))
    else $error("engine byte not stored");
  chk_read_module2: assert property (access && !pwrite && !bank_select_r
    && addr_ok && (idx == temp_window_pkg::IDX_BYTE7)
    |=> prdata_r == {24'h00_0000, $past(module2_r)})
    else $error("module 2 read mismatch");

  // Feed loads: each read-only reading copies its input on the update strobe; E0 does so only in sensor mode
  chk_platform_load: assert property (temp_update
    |=> platform_hub_r == $past(platform_hub_temp))
    else $error("platform hub byte not loaded");

  chk_whole_load: assert property (temp_update
    |=> cpu_whole_r == $past(cpu_whole_temp))
    else $error("cpu whole byte not loaded");

  chk_hub_load: assert property (temp_update
    |=> memory_hub_r == $past(memory_hub_temp))
    else $error("memory hub byte not loaded");

  chk_module0_load: assert property (temp_update
    |=> module0_r == $past(module0_temp))
    else $error("module 0 byte not loaded");

  chk_module1_load: assert property (temp_update
    |=> module1_r == $past(module1_temp))
    else $error("module 1 byte not loaded");

  chk_module2_load: assert property (temp_update
    |=> module2_r == $past(module2_temp))
    else $error("module 2 byte not loaded");

  chk_sensor_mode: assert property (temp_update && !sideband_mode_r
    |=> cpu_max_r == $past(cpu_sensor_temp))
    else $error("sensor reading not shown at E0");

  // Bus answers
  chk_buffer_read: assert property (access && !pwrite && bank_select_r && in_window
    |=> prdata_r == {24'h00_0000, $past(buffer_bytes[8*idx[2:0] +: 8])})
    else $error("buffer byte read mismatch");

  chk_count_read: assert property (access && !pwrite && addr_ok
    && (idx == temp_window_pkg::IDX_BLOCK_COUNT)
    |=> prdata_r == {24'h00_0000, $past(bank_select_r), 1'b0, $past(block_count_r)})
    else $error("block count read mismatch");

  chk_err_ready: assert property (pslverr_r |-> pready_r)
    else $error("error flag without ready");

  chk_upper_zero: assert property (pready_r
    |-> prdata_r[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  chk_ready_source: assert property (pready_r
    |-> $past(access))
    else $error("ready without access");

  // Register state
  chk_temp_bank_buf: assert property (write_fire && !bank_select_r && in_window
    && !engine_we |=> $stable(buffer_bytes))
    else $error("temperature bank write changed buffer");

  chk_count_write: assert property (write_fire && addr_ok
    && (idx == temp_window_pkg::IDX_BLOCK_COUNT) |=> block_count_r == $past(pwdata[5:0]))
    else $error("block count not written");

endmodule : temp_window

/* File: core/temp_window_pkg.sv */
// Constants for the banked temperature / serial buffer register window.
// Assumes an APB slave with 32-bit data and one register per aligned word.
package temp_window_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BYTE0 = 8'hE0;
  localparam logic [7:0] IDX_BYTE1 = 8'hE1;
  localparam logic [7:0] IDX_BYTE2 = 8'hE2;
  localparam logic [7:0] IDX_BYTE3 = 8'hE3;
  localparam logic [7:0] IDX_BYTE4 = 8'hE4;
  localparam logic [7:0] IDX_BYTE5 = 8'hE5;
  localparam logic [7:0] IDX_BYTE6 = 8'hE6;
  localparam logic [7:0] IDX_BYTE7 = 8'hE7;
  localparam logic [7:0] IDX_BLOCK_COUNT = 8'hEC;
  localparam logic [7:0] IDX_SIDEBAND_CTRL = 8'hF0;
  // Address split
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int NUM_BYTES = 8;
  // Block count register fields
  localparam int BANK_SELECT_BIT = 7;
  localparam int BLOCK_COUNT_W = 6;
  // Sideband control fields
  localparam int SIDEBAND_MODE_BIT = 0;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] COUNT_RESET = 6'h00;
  localparam logic BANK_RESET = 1'b0;
  localparam logic MODE_RESET = 1'b0;
  // Bank codes
  localparam logic BANK_TEMPERATURE = 1'b0;
  localparam logic BANK_BUFFER = 1'b1;
endpackage : temp_window_pkg

/* File: verif/feed_model.sv */
// Far side model: temperature feed and serial engine writes into the buffer.
// Assumes the bench commands it one pclk ahead of the window seeing it.
`timescale 1ns/1ns
module feed_model
(
  // Clock
  input wire logic pclk,
  // Commands from the bench
  input wire logic t_go,
  input wire logic [63:0] t_val,
  input wire logic e_go,
  input wire logic [2:0] e_idx,
  input wire logic [7:0] e_dat,
  // Toward the window
  output logic temp_update = 1'b0,
  output logic [63:0] temps = 64'h0000_0000_0000_0000,
  output logic engine_we = 1'b0,
  output logic [2:0] engine_index = 3'h0,
  output logic [7:0] engine_wdata = 8'h00
);
  // Lines move every cycle outside a strobe, so a stray capture shows
  always @(posedge pclk)
  begin
    temp_update <= t_go;
    temps <= t_go ? t_val : ~temps;
    engine_we <= e_go;
    engine_index <= e_go ? e_idx : ~engine_index;
    engine_wdata <= e_go ? e_dat : ~engine_wdata;
  end
endmodule : feed_model

/* File: verif/tb.sv */
// Bench for the banked window: APB master, far side model, checks.
// Assumes one APB wait state and readings taken only on temp_update.
`timescale 1ns/1ns
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, r;
  logic pready, pslverr, temp_update, engine_we, bank_select, sideband_mode, err;
  logic [63:0] temps, buffer_bytes, et;
  logic [63:0] t_val = 64'h0000_0000_0000_0000;
  logic [2:0] engine_index;
  logic [2:0] e_idx = 3'h0;
  logic [7:0] engine_wdata;
  logic [7:0] e_dat = 8'h00;
  logic [5:0] block_count;
  logic t_go = 1'b0;
  logic e_go = 1'b0;
  logic [31:0] seed = 32'h0000_B415;
  logic [7:0] eb [8];
  int fail_count = 0;
  int n_checks = 0;
  always #5 pclk = ~pclk;
  temp_window uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .temp_update(temp_update), .cpu_sensor_temp(temps[7:0]),
    .platform_hub_temp(temps[15:8]), .cpu_fraction_temp(temps[23:16]),
    .cpu_whole_temp(temps[31:24]), .memory_hub_temp(temps[39:32]),
    .module0_temp(temps[47:40]), .module1_temp(temps[55:48]), .module2_temp(temps[63:56]),
    .engine_we(engine_we), .engine_index(engine_index), .engine_wdata(engine_wdata),
    .buffer_bytes(buffer_bytes), .block_count(block_count), .bank_select(bank_select),
    .sideband_mode(sideband_mode));
  feed_model far (.pclk(pclk), .t_go(t_go), .t_val(t_val), .e_go(e_go), .e_idx(e_idx),
    .e_dat(e_dat), .temp_update(temp_update), .temps(temps), .engine_we(engine_we),
    .engine_index(engine_index), .engine_wdata(engine_wdata));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected temperature bank byte at slot i
  function automatic logic [7:0] tx(input logic [63:0] t, input logic md, input int i);
    logic [7:0] m;
    m = t[15:8];
    if (t[31:24] > m) m = t[31:24];
    if (t[39:32] > m) m = t[39:32];
    if (i != 0) return t[8*i +: 8];
    return md ? m : t[7:0];
  endfunction : tx
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request held until pready is sampled high; one idle edge after
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic feed(input logic tmp, input logic [63:0] v, input logic [2:0] i);
    t_go <= tmp;
    e_go <= !tmp;
    t_val <= v;
    e_idx <= i;
    e_dat <= v[7:0];
    @(posedge pclk);
    t_go <= 1'b0;
    e_go <= 1'b0;
    repeat (3) @(posedge pclk);
    if (tmp) et = v;
    else eb[i] = v[7:0];
  endtask : feed
  task automatic check_buf();
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'hE0 + 8'(i), 32'h0);
      chk("buffer", {24'h0, eb[i]}, rd);
      chk("buffer port", {24'h0, eb[i]}, {24'h0, buffer_bytes[8*i +: 8]});
    end
    $display("test done: buffer bank");
  endtask : check_buf
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'hE0 + 8'(i), 32'h0);
      chk("temp reset", 32'h0, rd);
      eb[i] = 8'h00;
    end
    r = rnd();
    apb(1'b1, temp_window_pkg::IDX_BLOCK_COUNT, {24'h0, 2'b11, r[5:0]});
    apb(1'b0, temp_window_pkg::IDX_BLOCK_COUNT, 32'h0);
    chk("count reg", {24'h0, 2'b10, r[5:0]}, rd);
    chk("bank port", 32'h1, 32'(bank_select));
    chk("count port", {26'h0, r[5:0]}, 32'(block_count));
    check_buf();
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      eb[i] = r[7:0];
      apb(1'b1, 8'hE0 + 8'(i), r);
    end
    check_buf();
    feed(1'b0, 64'(rnd()), 3'h0);
    feed(1'b0, 64'(rnd()), 3'h7);
    check_buf();
    apb(1'b1, temp_window_pkg::IDX_BLOCK_COUNT, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, temp_window_pkg::IDX_SIDEBAND_CTRL, 32'(k != 0));
      chk("mode port", 32'(k != 0), 32'(sideband_mode));
      r = rnd();
      feed(1'b1, (k == 2) ? 64'h0102_0304_1006_FE08 : {rnd(), r}, 3'h0);
      for (int i = 0; i < 8; i++)
      begin
        if (i > 0) apb(1'b1, 8'hE0 + 8'(i), 32'hFFFF_FFFF);
        apb(1'b0, 8'hE0 + 8'(i), 32'h0);
        chk("temp", {24'h0, tx(et, k != 0, i)}, rd);
      end
      $display("test done: temperature bank %0d", k);
    end
    apb(1'b1, 8'hE0, 32'h0000_005A);
    apb(1'b0, 8'hE0, 32'h0);
    chk("temp E0 write", 32'h0000_005A, rd);
    apb(1'b0, 8'hE8, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1'b1, temp_window_pkg::IDX_BLOCK_COUNT, 32'h0000_0080);
    check_buf();
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, temp_window_pkg::IDX_BLOCK_COUNT, 32'h0000_0080);
    for (int i = 0; i < 8; i++) eb[i] = 8'h00;
    check_buf();
    final_report();
  end
endmodule : tb
